// File: rtl/pwk_counters.sv
// Purpose: Wakeup divider and periodic-reset counter
// Assumes: tick is a one-cycle pulse per low-frequency period
// Notes: A zero wakeup interval runs the divider at 63 silently
`timescale 1ns/1ns

module pwk_counters (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic freeze,
	input wire logic restart_wake,
	input wire logic restart_rst,
	input wire logic [5:0] wake_interval,
	input wire logic [5:0] reset_interval,
	output logic [5:0] wake_cnt,
	output logic [5:0] rst_cnt,
	output logic wake_evt,
	output logic rst_evt
);
	typedef struct packed {
		logic [5:0] wcnt;
		logic [5:0] rcnt;
		logic wevt;
		logic revt;
	} pwk_cnt_st_t;

	pwk_cnt_st_t st_q, st_d;
	logic [5:0] wlimit;

	// Divider limit and count step
	always_comb begin
		st_d = st_q;
		st_d.wevt = 1'b0;
		st_d.revt = 1'b0;
		wlimit = (wake_interval == 6'h00) ? pwk_pkg::INTERVAL_RST : wake_interval;
		if (!freeze) begin
			if (restart_wake) begin
				st_d.wcnt = pwk_pkg::CNT_RST;
			end else if (tick) begin
				if (st_q.wcnt + 6'h01 >= wlimit) begin
					// Wrap to zero, a read right after the event sees zero
					st_d.wcnt = pwk_pkg::CNT_RST;
					st_d.wevt = (wake_interval != 6'h00);
					if (reset_interval != 6'h00) begin
						if (st_q.rcnt + 6'h01 >= reset_interval) begin
							st_d.rcnt = pwk_pkg::CNT_RST;
							st_d.revt = 1'b1;
						end else begin
							st_d.rcnt = st_q.rcnt + 6'h01;
						end
					end
				end else begin
					st_d.wcnt = st_q.wcnt + 6'h01;
				end
			end
			if (restart_rst) begin
				st_d.rcnt = pwk_pkg::CNT_RST;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign wake_cnt = st_q.wcnt;
	assign rst_cnt = st_q.rcnt;
	assign wake_evt = st_q.wevt;
	assign rst_evt = st_q.revt;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_freeze_holds: assert property (freeze |=> $stable(wake_cnt) && $stable(rst_cnt))
		else $error("counter moved while frozen");
	chk_event_zeroes: assert property (wake_evt |-> wake_cnt == 6'h00)
		else $error("wakeup counter not zero at its event");
endmodule // pwk_counters

// File: rtl/pwk_pkg.sv
// Purpose: Shared constants of the periodic wakeup unit
// Assumes: Byte-wide register port, 8-bit addresses
// Notes: Offsets other than the counter view are local choices

// ****************************************************************
// Package
// ****************************************************************
package pwk_pkg;
	localparam int CNT_W = 6;
	localparam logic [7:0] ADDR_STATUS = 8'h1F;
	localparam logic [7:0] ADDR_WAKE_CTL = 8'h20;
	localparam logic [7:0] ADDR_RST_CTL = 8'h21;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h22;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h23;
	// Field positions
	localparam int PAGE_BIT = 7;
	localparam int ZERO_BIT = 6;
	localparam int FLAG_BIT = 7;
	localparam int ACK_BIT = 6;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_RST = 1;
	// Reset values
	localparam logic [5:0] INTERVAL_RST = 6'h3F;
	localparam logic [5:0] CNT_RST = 6'h00;
	localparam logic [1:0] IRQ_RST_VAL = 2'h0;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic PAGE_RST = 1'b0;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage

// File: rtl/pwk_sync.sv
// Purpose: Two-stage synchroniser for the tick pin
// Assumes: Input asynchronous to clk_sys
// Notes: First stage is read by the second stage only
`timescale 1ns/1ns

module pwk_sync (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic meta;
		logic stable;
	} pwk_sync_st_t;

	pwk_sync_st_t st_q, st_d;

	// Shift chain
	always_comb begin
		st_d = st_q;
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;
endmodule // pwk_sync

// File: rtl/pwk_top.sv
// Purpose: Periodic wakeup unit, counter view and operating modes
// Assumes: Core-side strobes and mode levels are on clk_sys
// Notes: Only the tick pin crosses in through a synchroniser
`timescale 1ns/1ns

module pwk_top (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tick_pin,
	input wire logic background_debug,
	input wire logic light_stop,
	input wire logic deep_stop,
	input wire logic por_clear,
	input wire logic sys_reset,
	input wire logic interrupt_unmask_opcode,
	output logic wakeup_irq_req,
	output logic periodic_reset_req,
	output logic clock_restart_req,
	output logic deep_stop_exit_por,
	output logic reset_source_por_only,
	output logic irq
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic page;
		logic wakeup_flag;
		logic periodic_reset_flag;
		logic [5:0] wake_interval;
		logic [5:0] reset_interval;
		logic restart_wake;
		logic restart_rst;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [7:0] rdata;
		logic irq;
		logic wake_deferred;
		logic wake_req;
		logic reset_req;
		logic clk_restart;
		logic por_exit;
		logic srs_por;
		logic tick_prev;
	} pwk_top_st_t;

	pwk_top_st_t st_q, st_d;

	logic tick_sync;
	logic tick_pulse;
	logic [5:0] wake_cnt;
	logic [5:0] rst_cnt;
	logic wake_evt;
	logic rst_evt;
	logic [5:0] view;
	logic [5:0] new_wint;
	logic [5:0] new_rint;

	// ****************************************************************
	// Tick crossing and counters
	// ****************************************************************
	pwk_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in(tick_pin),
		.sync_out(tick_sync)
	);

	// Edge of the synchronised tick, one pulse per period
	assign tick_pulse = tick_sync & ~st_q.tick_prev;

	pwk_counters u_cnt (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(tick_pulse),
		.freeze(background_debug),
		.restart_wake(st_q.restart_wake),
		.restart_rst(st_q.restart_rst),
		.wake_interval(st_q.wake_interval),
		.reset_interval(st_q.reset_interval),
		.wake_cnt(wake_cnt),
		.rst_cnt(rst_cnt),
		.wake_evt(wake_evt),
		.rst_evt(rst_evt)
	);

	// Page bit picks the counter shown
	assign view = st_q.page ? rst_cnt : wake_cnt;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		st_d.tick_prev = tick_sync;
		st_d.restart_wake = 1'b0;
		st_d.restart_rst = 1'b0;
		st_d.reset_req = 1'b0;
		st_d.clk_restart = 1'b0;
		st_d.por_exit = 1'b0;
		new_wint = reg_wdata[5:0];
		new_rint = reg_wdata[5:0];

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				pwk_pkg::ADDR_STATUS: begin
					// Only the page bit takes the write
					st_d.page = reg_wdata[pwk_pkg::PAGE_BIT];
				end
				pwk_pkg::ADDR_WAKE_CTL: begin
					// Writing one to the ack clears the flag
					if (reg_wdata[pwk_pkg::ACK_BIT]) begin
						st_d.wakeup_flag = 1'b0;
					end
					// Both intervals zero at once is refused
					if (!(new_wint == 6'h00 && st_q.reset_interval == 6'h00) &&
						new_wint != st_q.wake_interval) begin
						// A changed interval restarts the timeout
						st_d.wake_interval = new_wint;
						st_d.restart_wake = 1'b1;
					end
				end
				pwk_pkg::ADDR_RST_CTL: begin
					// Writing one to the ack clears the flag
					if (reg_wdata[pwk_pkg::ACK_BIT]) begin
						st_d.periodic_reset_flag = 1'b0;
					end
					if (!(new_rint == 6'h00 && st_q.wake_interval == 6'h00) &&
						new_rint != st_q.reset_interval) begin
						st_d.reset_interval = new_rint;
						st_d.restart_rst = 1'b1;
					end
				end
				pwk_pkg::ADDR_IRQ_STAT: begin
					st_d.irq_stat = st_q.irq_stat & ~reg_wdata[1:0];
				end
				pwk_pkg::ADDR_IRQ_MASK: begin
					st_d.irq_mask = reg_wdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// Source indication cleared by core resets, the set below wins
		if (sys_reset || por_clear) begin
			st_d.srs_por = 1'b0;
		end

		// Wakeup event, set wins over a same-cycle ack
		if (wake_evt) begin
			st_d.wakeup_flag = 1'b1;
			st_d.irq_stat[pwk_pkg::IRQ_WAKE] = 1'b1;
			if (deep_stop) begin
				// Exit as power-on, interrupt held back
				st_d.por_exit = 1'b1;
				st_d.wake_deferred = 1'b1;
			end else if (light_stop) begin
				// Clocks first, vector follows next cycle
				st_d.clk_restart = 1'b1;
			end
		end

		// Periodic reset event
		if (rst_evt) begin
			// Flag set on every periodic reset
			st_d.periodic_reset_flag = 1'b1;
			st_d.irq_stat[pwk_pkg::IRQ_RST] = 1'b1;
			if (deep_stop) begin
				// Power-on exit, source shows power-on only
				st_d.por_exit = 1'b1;
				st_d.srs_por = 1'b1;
			end else begin
				// Light stop restarts clocks in the same cycle as the reset request
				st_d.clk_restart = light_stop;
				st_d.reset_req = 1'b1;
			end
		end

		// Deferred wakeup waits for the unmask opcode
		if (interrupt_unmask_opcode && !wake_evt) begin
			st_d.wake_deferred = 1'b0;
		end
		// Vector request follows the flag unless deferred
		// Vector waits one cycle behind the clock restart
		st_d.wake_req = st_d.wakeup_flag & ~st_d.wake_deferred & ~st_d.clk_restart;

		// Resets made by this unit are not fed back here
		// Deep stop exit leaves the registers alone
		if (sys_reset || por_clear) begin
			st_d.wake_interval = pwk_pkg::INTERVAL_RST;
			st_d.reset_interval = pwk_pkg::INTERVAL_RST;
			st_d.restart_wake = 1'b1;
			st_d.restart_rst = 1'b1;
		end
		// Only a true power-on clears page and flags
		if (por_clear) begin
			st_d.page = pwk_pkg::PAGE_RST;
			st_d.wakeup_flag = 1'b0;
			st_d.periodic_reset_flag = 1'b0;
			st_d.wake_deferred = 1'b0;
			st_d.wake_req = 1'b0;
		end

		// Read data, one cycle after the strobe
		st_d.rdata = pwk_pkg::RDATA_RST;
		if (reg_rd) begin
			unique case (reg_addr)
				pwk_pkg::ADDR_STATUS: begin
					// Snapshot taken on the read strobe
					// Selected count in the low bits
					st_d.rdata = {st_q.page, 1'b0, view};
				end
				pwk_pkg::ADDR_WAKE_CTL: begin
					st_d.rdata = {st_q.wakeup_flag, 1'b0, st_q.wake_interval};
				end
				pwk_pkg::ADDR_RST_CTL: begin
					st_d.rdata = {st_q.periodic_reset_flag, 1'b0, st_q.reset_interval};
				end
				pwk_pkg::ADDR_IRQ_STAT: begin
					st_d.rdata = {6'h00, st_q.irq_stat};
				end
				pwk_pkg::ADDR_IRQ_MASK: begin
					st_d.rdata = {6'h00, st_q.irq_mask};
				end
				default: begin
					st_d.rdata = pwk_pkg::RDATA_RST;
				end
			endcase
		end

		// Level interrupt from unmasked sticky bits
		st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.wake_interval <= pwk_pkg::INTERVAL_RST;
			st_q.reset_interval <= pwk_pkg::INTERVAL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = st_q.rdata;
	assign wakeup_irq_req = st_q.wake_req;
	assign periodic_reset_req = st_q.reset_req;
	assign clock_restart_req = st_q.clk_restart;
	assign deep_stop_exit_por = st_q.por_exit;
	assign reset_source_por_only = st_q.srs_por;
	assign irq = st_q.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_page_write_takes: assert property (
		reg_wr && reg_addr == pwk_pkg::ADDR_STATUS && !por_clear
		|=> st_q.page == $past(reg_wdata[7]))
		else $error("page bit did not take write");
	chk_page_por_clears: assert property (por_clear |=> !st_q.page)
		else $error("page bit survived power-on");
	chk_page_keeps: assert property (
		sys_reset && !por_clear && !reg_wr |=> $stable(st_q.page))
		else $error("page bit changed on other reset");
	chk_zero_bit_read: assert property (
		reg_rd && reg_addr == pwk_pkg::ADDR_STATUS |=> reg_rdata[6] == 1'b0)
		else $error("bit six read nonzero");
	chk_status_snapshot: assert property (
		reg_rd && reg_addr == pwk_pkg::ADDR_STATUS
		|=> reg_rdata[5:0] == ($past(st_q.page) ? $past(rst_cnt) : $past(wake_cnt)))
		else $error("status snapshot wrong");
	chk_wake_flag_set: assert property (wake_evt && !por_clear |=> st_q.wakeup_flag)
		else $error("wakeup flag not set");
	chk_ack_clears: assert property (
		reg_wr && reg_addr == pwk_pkg::ADDR_WAKE_CTL && reg_wdata[6] && !wake_evt
		|=> !st_q.wakeup_flag)
		else $error("ack did not clear flag");
	chk_reset_request: assert property (
		rst_evt && !deep_stop |=> periodic_reset_req ##1 !periodic_reset_req)
		else $error("reset request not one pulse");
	chk_light_restart: assert property (
		(wake_evt || rst_evt) && light_stop && !deep_stop |=> clock_restart_req)
		else $error("clocks not restarted");
	chk_deep_deferred: assert property (
		wake_evt && deep_stop && !por_clear
		|=> deep_stop_exit_por && !wakeup_irq_req)
		else $error("deep stop wakeup not deferred");
	chk_deep_source: assert property (
		rst_evt && deep_stop |=> reset_source_por_only && !periodic_reset_req)
		else $error("deep stop reset source wrong");
	chk_interval_preset: assert property (
		sys_reset |=> st_q.wake_interval == pwk_pkg::INTERVAL_RST &&
		st_q.reset_interval == pwk_pkg::INTERVAL_RST)
		else $error("intervals not preset");

	cov_wake_run: cover property (wake_evt && !light_stop && !deep_stop);
	cov_reset_light: cover property (rst_evt && light_stop);
	cov_deep_unmask: cover property (deep_stop_exit_por ##[1:50] wakeup_irq_req);
endmodule // pwk_top

// File: verification/pwk_core_model.sv
// Purpose: Behavioural core model beside the wakeup unit
// Assumes: Unit requests are one-cycle pulses on clk_sys
// Notes: Unit resets are only counted, never fed back as core resets
`timescale 1ns/1ns

module pwk_core_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic go_light,
	input wire logic go_deep,
	input wire logic periodic_reset_req,
	input wire logic clock_restart_req,
	input wire logic deep_stop_exit_por,
	output logic light_stop,
	output logic deep_stop,
	output int n_rst,
	output int n_restart,
	output int n_exit
);
	// ********************
	// Mode and request tracking
	// ********************
	// Stop levels fall once the unit wakes the core
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			light_stop <= 1'b0;
			deep_stop <= 1'b0;
			n_rst <= 0;
			n_restart <= 0;
			n_exit <= 0;
		end else begin
			light_stop <= go_light | (light_stop & ~clock_restart_req);
			deep_stop <= go_deep | (deep_stop & ~deep_stop_exit_por);
			n_rst <= n_rst + int'(periodic_reset_req);
			n_restart <= n_restart + int'(clock_restart_req);
			n_exit <= n_exit + int'(deep_stop_exit_por);
		end
	end
endmodule // pwk_core_model

// File: verification/testbench.sv
// Purpose: Self-checking bench for the periodic wakeup unit
// Assumes: Core model answers unit requests, no feedback resets
// Notes: Ticks spaced six clocks apart, above the minimum spacing
`timescale 1ns/1ns

module testbench;
	logic clk_sys, rst_n, reg_wr, reg_rd, tick_pin, background_debug;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rbuf;
	logic [4:0] pls;
	logic light_stop, deep_stop, wakeup_irq_req, periodic_reset_req;
	logic clock_restart_req, deep_stop_exit_por, reset_source_por_only, irq;
	int n_rst, n_restart, n_exit, errors, comparisons;
	// Pulse lines: light, deep, unmask, sys reset, power-on
	wire go_light = pls[0];
	wire go_deep = pls[1];
	wire unmask = pls[2];
	wire sys_reset = pls[3];
	wire por_clear = pls[4];

	pwk_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tick_pin(tick_pin), .background_debug(background_debug), .light_stop(light_stop),
		.deep_stop(deep_stop), .por_clear(por_clear), .sys_reset(sys_reset),
		.interrupt_unmask_opcode(unmask), .wakeup_irq_req(wakeup_irq_req),
		.periodic_reset_req(periodic_reset_req), .clock_restart_req(clock_restart_req),
		.deep_stop_exit_por(deep_stop_exit_por),
		.reset_source_por_only(reset_source_por_only), .irq(irq));

	pwk_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .go_light(go_light),
		.go_deep(go_deep), .periodic_reset_req(periodic_reset_req),
		.clock_restart_req(clock_restart_req), .deep_stop_exit_por(deep_stop_exit_por),
		.light_stop(light_stop), .deep_stop(deep_stop), .n_rst(n_rst),
		.n_restart(n_restart), .n_exit(n_exit));

	// ********************
	// Shared tasks
	// ********************
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask

	// Strobe held one cycle, released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		rbuf = reg_rdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(rbuf, exp);
	endtask

	task automatic pulse(input int k);
		@(posedge clk_sys);
		pls[k] <= 1'b1;
		@(posedge clk_sys);
		pls[k] <= 1'b0;
	endtask

	// Registered outputs need a couple of edges to land
	task automatic pause();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// Extra cycles at the end cover sync and event latency
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			tick_pin <= 1'b1;
			repeat (2) @(posedge clk_sys);
			tick_pin <= 1'b0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (6) @(posedge clk_sys);
		#1;
	endtask

	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ********************
	// Scenarios
	// ********************
	task automatic test_reset();
		rdc(8'h1F, 8'h00);
		rdc(8'h20, 8'h3F);
		rdc(8'h21, 8'h3F);
		rdc(8'h30, 8'h00);
		chb(irq, 1'b0);
		$display("test_reset done");
	endtask

	task automatic test_page();
		wr(8'h1F, 8'hFF);
		rdc(8'h1F, 8'h80);
		wr(8'h1F, 8'h00);
		rdc(8'h1F, 8'h00);
		$display("test_page done");
	endtask

	task automatic test_wake();
		wr(8'h23, 8'h01);
		wr(8'h20, 8'h05);
		tick(3);
		rdc(8'h1F, 8'h03);
		tick(2);
		rdc(8'h1F, 8'h00);
		rdc(8'h20, 8'h85);
		chb(wakeup_irq_req, 1'b1);
		chb(irq, 1'b1);
		wr(8'h23, 8'h00);
		pause();
		chb(irq, 1'b0);
		wr(8'h23, 8'h01);
		wr(8'h22, 8'h01);
		pause();
		chb(irq, 1'b0);
		wr(8'h20, 8'h05);
		rdc(8'h20, 8'h85);
		wr(8'h20, 8'h45);
		rdc(8'h20, 8'h05);
		chb(wakeup_irq_req, 1'b0);
		$display("test_wake done");
	endtask

	task automatic test_reset_interval();
		wr(8'h21, 8'h02);
		tick(5);
		wr(8'h1F, 8'h80);
		rdc(8'h1F, 8'h81);
		tick(5);
		chk(8'(n_rst), 8'h01);
		rdc(8'h21, 8'h82);
		rdc(8'h20, 8'h85);
		rdc(8'h1F, 8'h80);
		wr(8'h21, 8'h42);
		wr(8'h20, 8'h45);
		wr(8'h1F, 8'h00);
		rdc(8'h21, 8'h02);
		$display("test_reset_interval done");
	endtask

	task automatic test_light();
		pulse(0);
		tick(5);
		chk(8'(n_restart), 8'h01);
		chb(light_stop, 1'b0);
		rdc(8'h20, 8'h85);
		wr(8'h20, 8'h45);
		$display("test_light done");
	endtask

	task automatic test_deep();
		wr(8'h21, 8'h03);
		pulse(1);
		tick(5);
		chk(8'(n_exit), 8'h01);
		chb(wakeup_irq_req, 1'b0);
		pulse(2);
		pause();
		chb(wakeup_irq_req, 1'b1);
		wr(8'h20, 8'h45);
		wr(8'h21, 8'h01);
		pulse(1);
		tick(5);
		chb(reset_source_por_only, 1'b1);
		rdc(8'h21, 8'h81);
		rdc(8'h20, 8'h85);
		pulse(2);
		wr(8'h20, 8'h45);
		wr(8'h21, 8'h41);
		$display("test_deep done");
	endtask

	task automatic test_debug();
		@(posedge clk_sys);
		background_debug <= 1'b1;
		tick(3);
		rdc(8'h1F, 8'h00);
		@(posedge clk_sys);
		background_debug <= 1'b0;
		tick(2);
		rdc(8'h1F, 8'h02);
		$display("test_debug done");
	endtask

	task automatic test_resets();
		wr(8'h1F, 8'h80);
		wr(8'h20, 8'h07);
		pulse(3);
		pause();
		rdc(8'h20, 8'h3F);
		rdc(8'h21, 8'h3F);
		chb(reset_source_por_only, 1'b0);
		rd(8'h1F);
		chk(rbuf & 8'h80, 8'h80);
		pulse(4);
		pause();
		rd(8'h1F);
		chk(rbuf & 8'h80, 8'h00);
		$display("test_resets done");
	endtask

	// ********************
	// Main sequence
	// ********************
	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tick_pin = 1'b0;
		background_debug = 1'b0;
		pls = 5'h00;
		errors = 0;
		comparisons = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		test_reset();
		test_page();
		test_wake();
		test_reset_interval();
		test_light();
		test_deep();
		test_debug();
		test_resets();
		end_sim();
	end

	// Cuts a hang short well above the normal run length
	initial begin
		repeat (40000) @(posedge clk_sys);
		errors++;
		$display("unexpected at %0t: run did not finish", $time);
		end_sim();
	end
endmodule // testbench
